// ===== logic/psm_pkg.sv
// package for the power-state manager: states, clock selects, carriers
package psm_pkg;

  // power states, one-hot
  typedef enum logic [2:0] {
    PSM_ACTIVE = 3'b001,
    PSM_IDLE   = 3'b010,
    PSM_SLEEP  = 3'b100
  } psm_state_t;

  // core clock source select codes
  localparam logic [1:0] PSM_CLK_FAST_12M  = 2'h0; // fast osc divided by two
  localparam logic [1:0] PSM_CLK_FAST_IDLE = 2'h1; // fast osc divided to 4-6 MHz
  localparam logic [1:0] PSM_CLK_SLOW      = 2'h2; // slow osc direct

  // frequency figures in kHz, for reference by the clock unit
  localparam int PSM_FAST_OSC_KHZ   = 24000;
  localparam int PSM_SLOW_OSC_KHZ   = 100;
  localparam int PSM_ACTIVE_KHZ     = 12000;
  localparam int PSM_IDLE_MIN_KHZ   = 4000;
  localparam int PSM_IDLE_MAX_KHZ   = 6000;
  localparam int PSM_IDLE_DIVIDE    = PSM_FAST_OSC_KHZ / PSM_IDLE_MAX_KHZ;

  // wake and request events, all pin-level inputs
  typedef struct packed {
    logic cc_attached;   // type-c connection present
    logic pd_msg;        // pd message in progress on cc
    logic i2c_busy;      // i2c host traffic
    logic idle_req;      // firmware asks to drop to idle
    logic sleep_req;     // firmware asks to drop to sleep
  } psm_events_t;

  // clock and service controls toward the core
  typedef struct packed {
    logic       fast_osc_en;
    logic       slow_osc_en;
    logic [1:0] clk_sel;
    logic       pd_enable;
    logic       i2c_enable;
    logic       spi_enable;
    logic       pd_drop_msg;
  } psm_ctrl_t;

  localparam psm_ctrl_t PSM_CTRL_RESET = '{
    fast_osc_en: 1'b1, slow_osc_en: 1'b1, clk_sel: PSM_CLK_FAST_12M,
    pd_enable: 1'b1, i2c_enable: 1'b1, spi_enable: 1'b1, pd_drop_msg: 1'b0};

endpackage

// ===== logic/psm_power_manager.sv
// power-state manager: active/idle/sleep sequencing and clock control
`timescale 1ns/1ps
`default_nettype none

module psm_power_manager (
  input  wire logic                 clock,
  input  wire logic                 rstn,
  input  wire psm_pkg::psm_events_t events_in,
  input  wire logic                 regulator_from_vbus,
  input  wire logic                 boot_config_done,
  output psm_pkg::psm_state_t       power_state,
  output psm_pkg::psm_ctrl_t        core_ctrl,
  output logic                      sink_only,
  output logic                      host_ctrl_ready
);

  // two-flop synchronisers for all pin inputs
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] meta_reg;
  logic [NSYNC-1:0] sync_reg;
  assign raw_in = {events_in, regulator_from_vbus, boot_config_done};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          meta_reg[gi] <= 1'b0;
          sync_reg[gi] <= 1'b0;
        end else begin
          meta_reg[gi] <= raw_in[gi];
          sync_reg[gi] <= meta_reg[gi];
        end
      end
    end
  endgenerate

  psm_pkg::psm_events_t ev;
  logic                 vbus_s;
  logic                 boot_s;
  assign {ev, vbus_s, boot_s} = sync_reg;

  // previous attach level for attach/detach edge detection
  logic attach_prev_reg;
  logic attach_prev_next;
  logic pd_prev_reg;
  logic pd_prev_next;
  logic attach_chg;
  logic pd_start;
  logic pd_end;

  always_comb begin
    attach_prev_next = ev.cc_attached;
    pd_prev_next     = ev.pd_msg;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      attach_prev_reg <= 1'b0;
      pd_prev_reg     <= 1'b0;
    end else begin
      attach_prev_reg <= attach_prev_next;
      pd_prev_reg     <= pd_prev_next;
    end
  end

  assign attach_chg = ev.cc_attached ^ attach_prev_reg;
  assign pd_start   = ev.pd_msg & ~pd_prev_reg;
  assign pd_end     = ~ev.pd_msg & pd_prev_reg;

  // state machine with drop-next-message flag
  psm_pkg::psm_state_t state_reg;
  psm_pkg::psm_state_t state_next;
  logic                drop_reg;
  logic                drop_next;

  always_comb begin
    state_next = state_reg;
    drop_next  = drop_reg;
    // flag covers only the waking message
    // it clears when that message ends, so the partner's retry is served
    if (drop_reg && pd_end) begin
      drop_next = 1'b0;
    end
    case (state_reg)
      psm_pkg::PSM_ACTIVE: begin
        if (ev.sleep_req && !ev.cc_attached && !ev.i2c_busy && !attach_chg) begin
          state_next = psm_pkg::PSM_SLEEP;
        end else if (ev.idle_req && !ev.i2c_busy && !attach_chg) begin
          state_next = psm_pkg::PSM_IDLE;
        end
      end
      psm_pkg::PSM_IDLE: begin
        if (attach_chg || ev.i2c_busy) begin
          state_next = psm_pkg::PSM_ACTIVE;
        end else if (pd_start) begin
          state_next = psm_pkg::PSM_ACTIVE;
          drop_next  = 1'b1;
        end else if (ev.sleep_req && !ev.cc_attached) begin
          state_next = psm_pkg::PSM_SLEEP;
        end
      end
      psm_pkg::PSM_SLEEP: begin
        if (attach_chg || ev.i2c_busy || ev.cc_attached) begin
          state_next = psm_pkg::PSM_ACTIVE;
        end
      end
      default: begin
        state_next = psm_pkg::PSM_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg <= psm_pkg::PSM_ACTIVE;
      drop_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      drop_reg  <= drop_next;
    end
  end

  // clock and service controls, registered from the next state
  psm_pkg::psm_ctrl_t ctrl_reg;
  psm_pkg::psm_ctrl_t ctrl_next;
  logic               sink_reg;
  logic               sink_next;
  logic               host_reg;
  logic               host_next;

  always_comb begin
    ctrl_next = psm_pkg::PSM_CTRL_RESET;
    ctrl_next.slow_osc_en = 1'b1;
    case (state_next)
      psm_pkg::PSM_IDLE: begin
        ctrl_next.clk_sel    = psm_pkg::PSM_CLK_FAST_IDLE;
        ctrl_next.pd_enable  = 1'b0;
        ctrl_next.spi_enable = 1'b0;
      end
      psm_pkg::PSM_SLEEP: begin
        ctrl_next.fast_osc_en = 1'b0;
        ctrl_next.clk_sel     = psm_pkg::PSM_CLK_SLOW;
        ctrl_next.pd_enable   = 1'b0;
        ctrl_next.i2c_enable  = 1'b0;
        ctrl_next.spi_enable  = 1'b0;
      end
      default: begin
        ctrl_next.clk_sel = psm_pkg::PSM_CLK_FAST_12M;
      end
    endcase
    ctrl_next.pd_drop_msg = drop_next;
    sink_next = vbus_s;
    // host control after boot bundle load
    host_next = boot_s & ctrl_next.i2c_enable;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= psm_pkg::PSM_CTRL_RESET;
      sink_reg <= 1'b1; // safe until supply source is known
      host_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      sink_reg <= sink_next;
      host_reg <= host_next;
    end
  end

  assign power_state     = state_reg;
  assign core_ctrl       = ctrl_reg;
  assign sink_only       = sink_reg;
  assign host_ctrl_ready = host_reg;

  // assertions
  property p_one_state;
    @(posedge clock) disable iff (!rstn) $onehot(state_reg);
  endproperty
  a_one_state: assert property (p_one_state) else $error("state not one-hot");

  property p_sleep_unconn;
    @(posedge clock) disable iff (!rstn)
      (state_reg == psm_pkg::PSM_ACTIVE && state_next == psm_pkg::PSM_SLEEP) |-> !ev.cc_attached;
  endproperty
  a_sleep_unconn: assert property (p_sleep_unconn) else $error("sleep while connected");

  property p_sleep_clock;
    @(posedge clock) disable iff (!rstn)
      state_reg == psm_pkg::PSM_SLEEP |->
        !core_ctrl.fast_osc_en && core_ctrl.clk_sel == psm_pkg::PSM_CLK_SLOW;
  endproperty
  a_sleep_clock: assert property (p_sleep_clock) else $error("sleep clock wrong");

  property p_pd_wake;
    @(posedge clock) disable iff (!rstn)
      (state_reg == psm_pkg::PSM_IDLE && pd_start) |=> state_reg == psm_pkg::PSM_ACTIVE;
  endproperty
  a_pd_wake: assert property (p_pd_wake) else $error("pd did not wake idle");

  property p_drop_first;
    @(posedge clock) disable iff (!rstn)
      (state_reg == psm_pkg::PSM_IDLE && pd_start && !attach_chg && !ev.i2c_busy)
        |=> core_ctrl.pd_drop_msg;
  endproperty
  a_drop_first: assert property (p_drop_first) else $error("first message not dropped");

  property p_pd_only_active;
    @(posedge clock) disable iff (!rstn)
      core_ctrl.pd_enable |-> state_reg == psm_pkg::PSM_ACTIVE;
  endproperty
  a_pd_only_active: assert property (p_pd_only_active) else $error("pd outside active");

  property p_i2c_wake;
    @(posedge clock) disable iff (!rstn)
      (state_reg == psm_pkg::PSM_SLEEP && ev.i2c_busy) |=> state_reg == psm_pkg::PSM_ACTIVE;
  endproperty
  a_i2c_wake: assert property (p_i2c_wake) else $error("i2c did not wake sleep");

  property p_sink_only;
    @(posedge clock) disable iff (!rstn) vbus_s |=> sink_only;
  endproperty
  a_sink_only: assert property (p_sink_only) else $error("source allowed on vbus power");

  property p_slow_on;
    @(posedge clock) disable iff (!rstn) core_ctrl.slow_osc_en;
  endproperty
  a_slow_on: assert property (p_slow_on) else $error("slow oscillator off");

  property p_attach_wake;
    @(posedge clock) disable iff (!rstn)
      (state_reg != psm_pkg::PSM_ACTIVE && attach_chg) |=> state_reg == psm_pkg::PSM_ACTIVE;
  endproperty
  a_attach_wake: assert property (p_attach_wake) else $error("attach did not wake");

endmodule

`default_nettype wire

// ===== verif/psm_partner_model.sv
// far-side model: type-c port partner, i2c host and firmware requests
`timescale 1ns/1ps
`default_nettype none

module psm_partner_model (
  input  wire logic            clock,
  input  wire logic            attach,
  input  wire logic            send_msg,
  input  wire logic            host_access,
  input  wire logic [1:0]      low_req,
  output psm_pkg::psm_events_t events
);
  logic [4:0] msg_cnt_reg;

  // message then retry
  // a message lasts 4 cycles; the partner sends it again after a gap,
  // since a message that wakes the device is lost
  always @(posedge clock) begin
    if (send_msg && msg_cnt_reg == 5'h00) begin
      msg_cnt_reg <= 5'h01;
    end else if (msg_cnt_reg != 5'h00) begin
      msg_cnt_reg <= (msg_cnt_reg == 5'h10) ? 5'h00 : msg_cnt_reg + 5'h01;
    end
  end

  initial msg_cnt_reg = 5'h00;

  // host holds traffic until woken
  // the bench keeps host_access up until the state leaves sleep or idle
  assign events = '{cc_attached: attach,
                    pd_msg: (msg_cnt_reg >= 5'h01 && msg_cnt_reg <= 5'h04) ||
                            (msg_cnt_reg >= 5'h0d && msg_cnt_reg <= 5'h10),
                    i2c_busy: host_access, idle_req: low_req[0], sleep_req: low_req[1]};
endmodule

`default_nettype wire

// ===== verif/tb.sv
// self-checking bench for the power-state manager
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic                 clock, rstn, attach, send_msg, host_access, reg_vbus, boot_done;
  logic [1:0]           low_req;
  psm_pkg::psm_events_t events;
  psm_pkg::psm_state_t  power_state;
  psm_pkg::psm_ctrl_t   core_ctrl;
  logic                 sink_only, host_ctrl_ready;
  int                   err_total, n_tests, cycles;

  psm_partner_model far_u (.clock(clock), .attach(attach), .send_msg(send_msg),
    .host_access(host_access), .low_req(low_req), .events(events));

  psm_power_manager dut_u (.clock(clock), .rstn(rstn), .events_in(events),
    .regulator_from_vbus(reg_vbus), .boot_config_done(boot_done),
    .power_state(power_state), .core_ctrl(core_ctrl), .sink_only(sink_only),
    .host_ctrl_ready(host_ctrl_ready));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // hang guard: whole run is well under a thousand cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      err_total++;
      conclude();
    end
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // expected controls: fast, slow, select, pd, i2c, spi, drop
  function automatic psm_pkg::psm_ctrl_t ctrl_exp(psm_pkg::psm_state_t s, logic drop);
    case (s)
      psm_pkg::PSM_IDLE:  return '{1'b1, 1'b1, psm_pkg::PSM_CLK_FAST_IDLE, 1'b0, 1'b1, 1'b0, 1'b0};
      psm_pkg::PSM_SLEEP: return '{1'b0, 1'b1, psm_pkg::PSM_CLK_SLOW, 1'b0, 1'b0, 1'b0, 1'b0};
      default:            return '{1'b1, 1'b1, psm_pkg::PSM_CLK_FAST_12M, 1'b1, 1'b1, 1'b1, drop};
    endcase
  endfunction

  // bounded wait for a state, then judge state and controls together
  task automatic expect_state(input psm_pkg::psm_state_t s, input logic drop);
    for (int i = 0; i < 12 && power_state !== s; i++) @(posedge clock);
    #1;
    check({5'h00, power_state}, {5'h00, s});
    check(core_ctrl, ctrl_exp(s, drop));
  endtask

  task automatic enter(input logic [1:0] code, input psm_pkg::psm_state_t s);
    @(posedge clock) low_req <= code;
    expect_state(s, 1'b0);
    @(posedge clock) low_req <= 2'h0;
  endtask

  task automatic t_supply();
    @(posedge clock) reg_vbus <= 1'b1;
    repeat (6) @(posedge clock);
    check({7'h00, sink_only}, 8'h01);
    @(posedge clock) reg_vbus <= 1'b0;
    repeat (6) @(posedge clock);
    check({7'h00, sink_only}, 8'h00);
    check({7'h00, host_ctrl_ready}, 8'h00);
    @(posedge clock) boot_done <= 1'b1;
    repeat (6) @(posedge clock);
    check({7'h00, host_ctrl_ready}, 8'h01);
    $display("test supply done");
  endtask

  task automatic t_idle_wake();
    enter(2'h1, psm_pkg::PSM_IDLE);
    @(posedge clock) send_msg <= 1'b1;
    @(posedge clock) send_msg <= 1'b0;
    expect_state(psm_pkg::PSM_ACTIVE, 1'b1);
    // the retry reaches the core about ten cycles on and must not be marked
    repeat (9) @(posedge clock);
    check({7'h00, core_ctrl.pd_drop_msg}, 8'h00);
    repeat (15) @(posedge clock);
    check(core_ctrl, ctrl_exp(psm_pkg::PSM_ACTIVE, 1'b0));
    enter(2'h1, psm_pkg::PSM_IDLE);
    @(posedge clock) host_access <= 1'b1;
    expect_state(psm_pkg::PSM_ACTIVE, 1'b0);
    @(posedge clock) host_access <= 1'b0;
    $display("test idle wake done");
  endtask

  task automatic t_sleep();
    @(posedge clock) attach <= 1'b1;
    repeat (6) @(posedge clock);
    low_req <= 2'h2;
    repeat (10) @(posedge clock);
    expect_state(psm_pkg::PSM_ACTIVE, 1'b0);
    @(posedge clock) low_req <= 2'h0;
    enter(2'h1, psm_pkg::PSM_IDLE);
    @(posedge clock) attach <= 1'b0;
    expect_state(psm_pkg::PSM_ACTIVE, 1'b0);
    repeat (6) @(posedge clock);
    enter(2'h2, psm_pkg::PSM_SLEEP);
    @(posedge clock) send_msg <= 1'b1;
    @(posedge clock) send_msg <= 1'b0;
    repeat (24) @(posedge clock);
    expect_state(psm_pkg::PSM_SLEEP, 1'b0);
    check({7'h00, host_ctrl_ready}, 8'h00);
    @(posedge clock) host_access <= 1'b1;
    expect_state(psm_pkg::PSM_ACTIVE, 1'b0);
    @(posedge clock) host_access <= 1'b0;
    enter(2'h2, psm_pkg::PSM_SLEEP);
    @(posedge clock) attach <= 1'b1;
    expect_state(psm_pkg::PSM_ACTIVE, 1'b0);
    $display("test sleep done");
  endtask

  // reset in mid-run from idle: everything returns to the safe defaults
  task automatic t_reset();
    enter(2'h1, psm_pkg::PSM_IDLE);
    @(posedge clock) rstn <= 1'b0;
    repeat (2) @(posedge clock);
    check(core_ctrl, psm_pkg::PSM_CTRL_RESET);
    check({4'h0, power_state, sink_only}, {4'h0, psm_pkg::PSM_ACTIVE, 1'b1});
    check({7'h00, host_ctrl_ready}, 8'h00);
    @(posedge clock) rstn <= 1'b1;
    repeat (6) @(posedge clock);
    check({5'h00, power_state}, {5'h00, psm_pkg::PSM_ACTIVE});
    check({7'h00, sink_only}, 8'h00);
    check({7'h00, host_ctrl_ready}, 8'h01);
    $display("test reset done");
  endtask

  initial begin
    {rstn, attach, send_msg, host_access, reg_vbus, boot_done} = 6'h00;
    low_req = 2'h0;
    {err_total, n_tests, cycles} = 0;
    repeat (20) @(posedge clock);
    check(core_ctrl, psm_pkg::PSM_CTRL_RESET);
    check({4'h0, power_state, sink_only}, {4'h0, psm_pkg::PSM_ACTIVE, 1'b1});
    @(posedge clock) rstn <= 1'b1;
    t_supply();
    t_idle_wake();
    t_sleep();
    t_reset();
    conclude();
  end
endmodule

`default_nettype wire
